// File: rtl/mfq_pkg.sv
package mfq_pkg;

    // error word bit positions
    localparam int ERR_W            = 16;
    localparam int ERR_AWAIT        = 0;
    localparam int ERR_NO_POWER     = 1;
    localparam int ERR_DRIVER       = 2;
    localparam int ERR_IN_INVALID   = 3;
    localparam int ERR_IN_DISC      = 4;
    localparam int ERR_FB_DISC      = 5;
    localparam int ERR_CURRENT      = 6;
    localparam int ERR_FRAMING      = 7;
    localparam int ERR_OVERRUN      = 8;
    localparam int ERR_QUEUE_FULL   = 9;
    localparam int ERR_CHECKSUM     = 10;
    localparam int ERR_FORMAT       = 11;
    localparam int ERR_LINK_TMO     = 12;
    localparam logic [15:0] ERR_USED_MASK  = 16'h1fff;
    localparam logic [15:0] ERR_KEEP_AWAIT = 16'h0001;
    localparam logic [15:0] ERR_RESET      = 16'h0001;

    // command bytes, always seen with the top bit set
    localparam logic [7:0] CMD_HALT_QUERY = 8'hb3;
    localparam logic [7:0] CMD_OCC_QUERY  = 8'hb5;
    localparam logic [7:0] CMD_READ_FIRST = 8'h81;
    localparam logic [7:0] CMD_READ_LAST  = 8'hbf;
    localparam logic [7:0] CMD_READ_TWO   = 8'ha1;
    localparam logic [7:0] CMD_MOTOR_OFF  = 8'hff;
    localparam logic [7:0] CMD_LOW_REV    = 8'he0;
    localparam logic [7:0] CMD_LOW_FWD    = 8'he1;
    localparam logic [2:0] CMD_SET_HI_TAG = 3'h6;
    localparam logic [7:0] CMD_TOP_BIT    = 8'h80;

    // variable indices of the read table
    localparam logic [3:0] VAR_INPUT   = 4'h0;
    localparam logic [3:0] VAR_TARGET  = 4'h1;
    localparam logic [3:0] VAR_FB      = 4'h2;
    localparam logic [3:0] VAR_SFB     = 4'h3;
    localparam logic [3:0] VAR_ESUM    = 4'h4;
    localparam logic [3:0] VAR_DTARGET = 4'h5;
    localparam logic [3:0] VAR_DUTY    = 4'h6;
    localparam logic [3:0] VAR_CURRENT = 4'h7;
    localparam logic [3:0] VAR_PCOUNT  = 4'h8;

    // input modes
    localparam logic [1:0] IN_MODE_ANALOG = 2'h0;
    localparam logic [1:0] IN_MODE_PULSE  = 2'h1;
    localparam logic [1:0] IN_MODE_SERIAL = 2'h2;

    // timing
    localparam int CLK_HZ          = 125_000_000;
    localparam int IN_TIMEOUT_MS   = 120;
    localparam int IN_TIMEOUT_CYC  = CLK_HZ / 1000 * IN_TIMEOUT_MS;
    localparam logic [2:0] PULSE_RUN_LEN = 3'h4;

    typedef struct packed {
        logic       two;
        logic       high;
        logic [3:0] idx;
    } mfq_rd_t;

endpackage : mfq_pkg

// File: rtl/mfq_pulse_qual.sv
`timescale 1ns/10ps
`default_nettype none
module mfq_pulse_qual
    import mfq_pkg::*;
#(
    parameter int TIMEOUT_CYC = IN_TIMEOUT_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        pulse_mode,
    input  wire logic        pulse_done,
    input  wire logic        pulse_good,
    input  wire logic [11:0] pulse_width,
    output logic      [11:0] input_value,
    output logic             input_invalid
);

    typedef struct packed {
        logic [2:0]  run;
        logic [11:0] value;
        logic [23:0] idle;
        logic        invalid;
    } mfq_pq_st_t;

    localparam mfq_pq_st_t PQ_RESET = '0;
    localparam logic [23:0] TMO     = 24'(TIMEOUT_CYC);

    mfq_pq_st_t st_reg;
    mfq_pq_st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (!pulse_mode) begin
            // flag never raised outside pulse mode
            st_next.idle    = '0;
            st_next.invalid = 1'b0;
            st_next.run     = '0;
        end else begin
            if (st_reg.idle > TMO) begin
                st_next.invalid = 1'b1;
            end else begin
                st_next.idle = st_reg.idle + 24'h000001;
            end
            if (pulse_done) begin
                if (!pulse_good) begin
                    st_next.run = '0;
                end else if (st_reg.run + 3'h1 >= PULSE_RUN_LEN) begin
                    // every good pulse that closes a run of four updates
                    st_next.run     = PULSE_RUN_LEN;
                    st_next.value   = pulse_width;
                    st_next.idle    = '0;
                    st_next.invalid = 1'b0;
                end else begin
                    st_next.run = st_reg.run + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= PQ_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign input_value   = st_reg.value;
    assign input_invalid = st_reg.invalid;

endmodule : mfq_pulse_qual
`default_nettype wire

// File: rtl/mfq_reply_tx.sv
`timescale 1ns/10ps
`default_nettype none
module mfq_reply_tx
    import mfq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       load,
    input  wire logic       two,
    input  wire logic [7:0] byte0,
    input  wire logic [7:0] byte1,
    input  wire logic       tx_ready,
    output logic            tx_valid,
    output logic      [7:0] tx_data,
    output logic            busy
);

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_FIRST,
        TX_SECOND
    } mfq_tx_state_t;

    typedef struct packed {
        mfq_tx_state_t state;
        logic          two;
        logic [7:0]    hold;
        logic [7:0]    data;
        logic          valid;
        logic          busy;
    } mfq_tx_st_t;

    localparam mfq_tx_st_t TX_RESET = '0;

    mfq_tx_st_t st_reg;
    mfq_tx_st_t st_next;

    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            TX_IDLE: begin
                // a load while busy cannot happen: the caller waits on busy
                if (load) begin
                    st_next.state = TX_FIRST;
                    st_next.two   = two;
                    st_next.data  = byte0;
                    st_next.hold  = byte1;
                    st_next.valid = 1'b1;
                    st_next.busy  = 1'b1;
                end
            end
            TX_FIRST: begin
                if (tx_ready) begin
                    if (st_reg.two) begin
                        st_next.state = TX_SECOND;
                        st_next.data  = st_reg.hold;
                    end else begin
                        st_next.state = TX_IDLE;
                        st_next.valid = 1'b0;
                        st_next.busy  = 1'b0;
                    end
                end
            end
            TX_SECOND: begin
                if (tx_ready) begin
                    st_next.state = TX_IDLE;
                    st_next.valid = 1'b0;
                    st_next.busy  = 1'b0;
                end
            end
            default: begin
                st_next = TX_RESET;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= TX_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tx_valid = st_reg.valid;
    assign tx_data  = st_reg.data;
    assign busy     = st_reg.busy;

endmodule : mfq_reply_tx
`default_nettype wire

// File: rtl/mfq_fault_query.sv
// How it works
// - pulse input updates after four good pulses
// - input-invalid after 120 ms without pulse update
// - input out of limits or aux open
// - feedback out of limits or aux open
// - current above limit sets bit 6
// - missing stop bit sets bit 7
// - byte into full receive buffer sets 8
// - secondary queue full drops byte, bit 9
// - bad check byte discards packet, bit 10
// - unknown or malformed packet sets bit 11
// - serial timeout elapsed sets bit 12
// - bits 13 to 15 read zero
// - error word sent low byte first
// - awaiting bit holds until setpoint, no drive
// - halting query replies, clears all but awaiting
// - disabled errors never reported as halting; awaiting cannot be disabled
// - red led and error line on halts other than awaiting
// - occurred query replies then restarts accumulation
// - one occurred accumulator for all requesters
// - two-byte reads go low byte first
// - low or high read returns one byte
// - read codes two, low, high per variable
// - unlisted 0x81-0xbf codes reply, no error
// - period counter increments and wraps at 16 bits
`timescale 1ns/10ps
`default_nettype none
module mfq_fault_query
    import mfq_pkg::*;
#(
    parameter int IN_TMO_CYC = IN_TIMEOUT_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_byte,
    input  wire logic [6:0]  cmd_arg,
    input  wire logic        cmd_crc_bad,
    input  wire logic        malformed_evt,
    input  wire logic        framing_evt,
    input  wire logic        overrun_evt,
    input  wire logic        queue_full_evt,
    input  wire logic        no_power,
    input  wire logic        driver_fault,
    input  wire logic        in_aux_open,
    input  wire logic        fb_aux_open,
    input  wire logic [1:0]  input_mode,
    input  wire logic        pulse_done,
    input  wire logic        pulse_good,
    input  wire logic [11:0] pulse_width,
    input  wire logic [11:0] analog_input,
    input  wire logic [11:0] in_abs_max,
    input  wire logic [11:0] in_abs_min,
    input  wire logic [11:0] target,
    input  wire logic [11:0] feedback,
    input  wire logic [11:0] fb_abs_max,
    input  wire logic [11:0] fb_abs_min,
    input  wire logic [11:0] scaled_feedback,
    input  wire logic [15:0] duty_target,
    input  wire logic [15:0] duty_cycle,
    input  wire logic [7:0]  motor_current,
    input  wire logic [7:0]  current_limit,
    input  wire logic [15:0] err_enable,
    input  wire logic        serial_tmo_en,
    input  wire logic [23:0] serial_tmo_cyc,
    input  wire logic        period_tick,
    input  wire logic        tx_ready,
    output logic             cmd_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    output logic             motor_drive,
    output logic             red_led,
    output logic             err_line,
    output logic      [15:0] halting_flags,
    output logic      [15:0] control_period_counter
);

    typedef struct packed {
        logic        ready;
        logic        load;
        logic        two;
        logic [7:0]  b0;
        logic [7:0]  b1;
        logic [15:0] halt;
        logic [15:0] occ;
        logic [23:0] link_idle;
        logic [15:0] pcount;
        logic [15:0] esum;
        logic        drive;
        logic        alarm;
    } mfq_st_t;

    localparam mfq_st_t ST_RESET = '{
        ready: 1'b1, load: 1'b0, two: 1'b0, b0: 8'h00, b1: 8'h00,
        halt: ERR_RESET, occ: ERR_RESET, link_idle: 24'h000000,
        pcount: 16'h0000, esum: 16'h0000, drive: 1'b0, alarm: 1'b0
    };

    // read codes: odd codes from 0xa1 are two-byte, below that odd is low
    function automatic mfq_rd_t read_code(input logic [7:0] c);
        mfq_rd_t    r;
        logic [7:0] off;
        r.two  = (c >= CMD_READ_TWO);
        r.high = !r.two && !c[0];
        off    = r.two ? (c - CMD_READ_TWO) : (c - CMD_READ_FIRST);
        r.idx  = off[4:1];
        return r;
    endfunction : read_code

    mfq_st_t     st_reg;
    mfq_st_t     st_next;
    logic [11:0] pulse_value;
    logic        pulse_invalid;
    logic        tx_busy;
    logic [11:0] in_value;
    logic [15:0] cur;
    logic [15:0] en;
    logic [15:0] rd_val;
    logic [15:0] err_sum_step;
    mfq_rd_t     rd;
    logic        take;
    logic        accepted;
    logic        is_read;
    logic        is_setpoint;
    logic        is_off;
    logic        is_unknown;

    mfq_pulse_qual #(
        .TIMEOUT_CYC   (IN_TMO_CYC)
    ) u_pulse (
        .clk           (clk),
        .rst           (rst),
        .pulse_mode    (input_mode == IN_MODE_PULSE),
        .pulse_done    (pulse_done),
        .pulse_good    (pulse_good),
        .pulse_width   (pulse_width),
        .input_value   (pulse_value),
        .input_invalid (pulse_invalid)
    );

    mfq_reply_tx u_tx (
        .clk      (clk),
        .rst      (rst),
        .load     (st_reg.load),
        .two      (st_reg.two),
        .byte0    (st_reg.b0),
        .byte1    (st_reg.b1),
        .tx_ready (tx_ready),
        .tx_valid (tx_valid),
        .tx_data  (tx_data),
        .busy     (tx_busy)
    );

    always_comb begin
        st_next  = st_reg;
        in_value = (input_mode == IN_MODE_PULSE) ? pulse_value
                                                 : analog_input;
        take     = cmd_valid && st_reg.ready;
        // a packet with a bad check byte is dropped whole
        accepted = take && !cmd_crc_bad;
        rd       = read_code(cmd_byte);
        is_read  = (cmd_byte >= CMD_READ_FIRST)
                && (cmd_byte <= CMD_READ_LAST);
        is_setpoint = (cmd_byte[7:5] == CMD_SET_HI_TAG)
                   || (cmd_byte == CMD_LOW_FWD)
                   || ((cmd_byte == CMD_LOW_REV) && (cmd_arg != 7'h00));
        is_off   = (cmd_byte == CMD_MOTOR_OFF)
                || ((cmd_byte == CMD_LOW_REV) && (cmd_arg == 7'h00));
        is_unknown = !is_read && !is_setpoint && !is_off;

        // awaiting bit is never maskable
        en = (err_enable | ERR_KEEP_AWAIT) & ERR_USED_MASK;

        cur = 16'h0000;
        cur[ERR_NO_POWER]   = no_power;
        cur[ERR_DRIVER]     = driver_fault;
        cur[ERR_IN_INVALID] = pulse_invalid;
        cur[ERR_IN_DISC]    = (in_value > in_abs_max)
                           || (in_value < in_abs_min) || in_aux_open;
        cur[ERR_FB_DISC]    = (feedback > fb_abs_max)
                           || (feedback < fb_abs_min) || fb_aux_open;
        cur[ERR_CURRENT]    = motor_current > current_limit;
        cur[ERR_FRAMING]    = framing_evt;
        cur[ERR_OVERRUN]    = overrun_evt;
        cur[ERR_QUEUE_FULL] = queue_full_evt;
        cur[ERR_CHECKSUM]   = take && cmd_crc_bad;
        cur[ERR_FORMAT]     = malformed_evt
                           || (accepted && is_unknown);

        // link watchdog, restarted by every good command
        if (!serial_tmo_en || (accepted && !is_unknown)) begin
            st_next.link_idle = 24'h000000;
        end else if (st_reg.link_idle + 24'h000001 >= serial_tmo_cyc) begin
            cur[ERR_LINK_TMO] = 1'b1;
            st_next.link_idle = 24'h000000;
        end else begin
            st_next.link_idle = st_reg.link_idle + 24'h000001;
        end

        // read table; undocumented codes answer zero
        case (rd.idx)
            VAR_INPUT:   rd_val = {4'h0, in_value};
            VAR_TARGET:  rd_val = {4'h0, target};
            VAR_FB:      rd_val = {4'h0, feedback};
            VAR_SFB:     rd_val = {4'h0, scaled_feedback};
            VAR_ESUM:    rd_val = st_reg.esum;
            VAR_DTARGET: rd_val = duty_target;
            VAR_DUTY:    rd_val = duty_cycle;
            VAR_CURRENT: rd_val = {8'h00, motor_current};
            VAR_PCOUNT:  rd_val = st_reg.pcount;
            default:     rd_val = 16'h0000;
        endcase

        st_next.load = 1'b0;
        if (accepted && is_read) begin
            st_next.load = 1'b1;
            if (cmd_byte == CMD_HALT_QUERY) begin
                st_next.two = 1'b1;
                st_next.b0  = st_reg.halt[7:0];
                st_next.b1  = st_reg.halt[15:8];
            end else if (cmd_byte == CMD_OCC_QUERY) begin
                st_next.two = 1'b1;
                st_next.b0  = st_reg.occ[7:0];
                st_next.b1  = st_reg.occ[15:8];
            end else begin
                st_next.two = rd.two;
                st_next.b0  = rd.high ? rd_val[15:8]
                                      : rd_val[7:0];
                st_next.b1  = rd_val[15:8];
            end
        end

        // halting latch: clear first, new events win over the clear
        st_next.halt = st_reg.halt;
        if (accepted && (cmd_byte == CMD_HALT_QUERY)) begin
            st_next.halt = st_reg.halt & ERR_KEEP_AWAIT;
        end
        if (accepted && is_setpoint) begin
            st_next.halt[ERR_AWAIT] = 1'b0;
        end
        if (accepted && is_off) begin
            st_next.halt[ERR_AWAIT] = 1'b1;
        end
        st_next.halt = (st_next.halt | cur) & en;

        // shared history, whichever requester clears it
        st_next.occ = (accepted && (cmd_byte == CMD_OCC_QUERY))
                    ? 16'h0000 : st_reg.occ;
        st_next.occ = (st_next.occ | cur | st_next.halt)
                    & ERR_USED_MASK;

        st_next.drive = (st_next.halt == 16'h0000);
        st_next.alarm = |(st_next.halt & ~ERR_KEEP_AWAIT);

        err_sum_step = st_reg.esum
                     + ({4'h0, scaled_feedback} - {4'h0, target});
        if (period_tick) begin
            st_next.pcount = st_reg.pcount + 16'h0001;
        end
        if (!st_reg.drive) begin
            st_next.esum = 16'h0000;
        end else if (period_tick) begin
            // wraps rather than saturates; no integral limit here
            st_next.esum = err_sum_step;
        end

        // stays low from a take until the reply has left
        st_next.ready = !(take || st_reg.load || tx_busy);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cmd_ready              = st_reg.ready;
    assign motor_drive            = st_reg.drive;
    assign red_led                = st_reg.alarm;
    assign err_line               = st_reg.alarm;
    assign halting_flags          = st_reg.halt;
    assign control_period_counter = st_reg.pcount;

endmodule : mfq_fault_query
`default_nettype wire

// File: testbench/mfq_fault_query_chk.sv
`timescale 1ns/10ps
`default_nettype none
module mfq_fault_query_chk
    import mfq_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_byte,
    input wire logic        cmd_crc_bad,
    input wire logic [7:0]  motor_current,
    input wire logic [7:0]  current_limit,
    input wire logic [15:0] err_enable,
    input wire logic        period_tick,
    input wire logic        tx_ready,
    input wire logic        cmd_ready,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        motor_drive,
    input wire logic        red_led,
    input wire logic        err_line,
    input wire logic [15:0] halting_flags,
    input wire logic [15:0] control_period_counter
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire take = cmd_valid && cmd_ready;
    a_query_reply: assert property (
        take && !cmd_crc_bad && (cmd_byte == CMD_HALT_QUERY
        || cmd_byte == CMD_OCC_QUERY) |-> ##2 tx_valid)
        else $error("query reply late");
    a_reply_alone: assert property (tx_valid |-> !cmd_ready)
        else $error("command taken during reply");
    a_reply_stands: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped");
    a_reserved_zero: assert property (halting_flags[15:13] == 3'h0)
        else $error("reserved bits set");
    a_led_line: assert property (red_led == err_line)
        else $error("led and error line differ");
    a_led_follows: assert property (
        (|halting_flags[12:1]) [*2] |-> red_led && !motor_drive)
        else $error("halting error not shown");
    a_count_step: assert property (
        period_tick |=> control_period_counter
        == $past(control_period_counter) + 16'h0001)
        else $error("period counter step");
    a_current_flag: assert property (
        motor_current > current_limit && err_enable[ERR_CURRENT]
        |-> ##[1:3] halting_flags[ERR_CURRENT])
        else $error("current flag missing");
    c_halt: cover property (take && cmd_byte == CMD_HALT_QUERY);
    c_stall: cover property (tx_valid && !tx_ready);
    c_drive: cover property (motor_drive);
endmodule : mfq_fault_query_chk
`default_nettype wire

// File: testbench/mfq_host_sink.sv
`timescale 1ns/10ps
`default_nettype none
module mfq_host_sink (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       stall,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    // host side; commands reach the block already framed, start byte
    // and device number stripped, so only the reply path is modelled
    logic [7:0] rx_q[$];
    logic       slow_reg = 1'h0;
    always @(posedge clk) begin
        if (tx_valid && tx_ready) rx_q.push_back(tx_data);
        slow_reg <= stall ? ~slow_reg : 1'h1;
    end
    // a stalled host takes a byte only every other cycle
    assign tx_ready = ~rst && slow_reg;
endmodule : mfq_host_sink
`default_nettype wire

// File: testbench/mfq_fault_query_bench.sv
`timescale 1ns/10ps
`default_nettype none
module mfq_fault_query_bench;
    import mfq_pkg::*;
    logic clk = 1'h0, rst = 1'h1, stall = 1'h0;
    logic cmd_valid = 1'h0, cmd_crc_bad = 1'h0, malformed_evt = 1'h0;
    logic framing_evt = 1'h0, overrun_evt = 1'h0, queue_full_evt = 1'h0;
    logic no_power = 1'h0, driver_fault = 1'h0, in_aux_open = 1'h0;
    logic fb_aux_open = 1'h0, serial_tmo_en = 1'h0, period_tick = 1'h0;
    logic pulse_done = 1'h0, pulse_good = 1'h0;
    logic [1:0] input_mode = 2'h0;
    logic [7:0] cmd_byte = 8'h00, motor_current = 8'h37;
    logic [7:0] current_limit = 8'hc8, tx_data;
    logic [6:0] cmd_arg = 7'h00;
    logic [11:0] pulse_width = 12'h000, analog_input = 12'h5a3;
    logic [11:0] in_abs_max = 12'hff0, in_abs_min = 12'h010;
    logic [11:0] target = 12'h9c4, feedback = 12'h321;
    logic [11:0] fb_abs_max = 12'hff0, fb_abs_min = 12'h010;
    logic [11:0] scaled_feedback = 12'h456;
    logic [15:0] duty_target = 16'hfffe, duty_cycle = 16'hfda8;
    logic [15:0] err_enable = 16'hffff, rep, halting_flags;
    logic [15:0] control_period_counter;
    logic [23:0] serial_tmo_cyc = 24'h000028;
    logic tx_ready, cmd_ready, tx_valid, motor_drive, red_led, err_line;
    int miscompares = 0;
    int cmp_count = 0;
    // short input timeout keeps the invalid-input case quick
    mfq_fault_query #(.IN_TMO_CYC(50)) u_dut (.*);
    mfq_host_sink u_sink (.*);
    initial forever #4 clk = ~clk;
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic send(input logic [7:0] cb, input logic [6:0] arg,
                        input logic bad, input int nb);
        int n;
        {cmd_byte, cmd_arg, cmd_crc_bad, cmd_valid} <= {cb, arg, bad, 1'h1};
        @(posedge clk);
        for (n = 0; n < 20 && cmd_ready !== 1'h1; n++) @(posedge clk);
        cmd_valid <= 1'h0;
        @(posedge clk);
        for (n = 0; n < 300 && cmd_ready !== 1'h1; n++) @(posedge clk);
        check("ready", 16'h0001, {15'h0000, cmd_ready});
        check("reply bytes", 16'(nb), 16'(u_sink.rx_q.size()));
        rep = 16'h0000;
        for (n = 0; n < nb && u_sink.rx_q.size() > 0; n++)
            rep[8*n +: 8] = u_sink.rx_q.pop_front();
        u_sink.rx_q.delete();
    endtask : send
    task automatic pulses(input int cnt, input logic good,
                          input logic [11:0] w);
        repeat (cnt) begin
            {pulse_width, pulse_good, pulse_done} <= {w, good, 1'h1};
            @(posedge clk);
            pulse_done <= 1'h0;
            @(posedge clk);
        end
    endtask : pulses
    task automatic t_reads();
        logic [7:0] code [12] = '{8'ha1, 8'h81, 8'h82, 8'ha3, 8'ha5,
            8'h87, 8'ha9, 8'hab, 8'h8e, 8'h8f, 8'h91, 8'hb7};
        int nb [12] = '{2, 1, 1, 2, 2, 1, 2, 2, 1, 1, 1, 2};
        logic [15:0] exp [12];
        exp = '{{4'h0, analog_input}, {8'h00, analog_input[7:0]},
            {12'h000, analog_input[11:8]}, {4'h0, target},
            {4'h0, feedback}, {8'h00, scaled_feedback[7:0]}, 16'h0000,
            duty_target, {8'h00, duty_cycle[15:8]},
            {8'h00, motor_current}, 16'h0003, 16'h0000};
        repeat (3) begin
            period_tick <= 1'h1;
            @(posedge clk);
            period_tick <= 1'h0;
            @(posedge clk);
        end
        for (int i = 0; i < 12; i++) begin
            send(code[i], 7'h00, 1'h0, nb[i]);
            check("read", exp[i], rep);
        end
        check("format", 16'h0001, halting_flags);
        $display("read test done");
    endtask : t_reads
    task automatic t_setpoint();
        send(CMD_LOW_FWD, 7'h10, 1'h0, 0);
        check("run", 16'h0000, halting_flags);
        send(CMD_LOW_REV, 7'h00, 1'h0, 0);
        check("stop", 16'h0001, {halting_flags[15:1], !motor_drive});
        send(8'hdd, 7'h64, 1'h0, 0);
        check("rerun", 16'h0001, {halting_flags[15:1], motor_drive});
        $display("setpoint test done");
    endtask : t_setpoint
    task automatic t_events();
        {framing_evt, queue_full_evt} <= 2'h3;
        err_enable[ERR_OVERRUN] <= 1'h0;
        @(posedge clk);
        {framing_evt, queue_full_evt, overrun_evt} <= 3'h1;
        @(posedge clk);
        overrun_evt <= 1'h0;
        send(8'hf0, 7'h00, 1'h0, 0);
        send(CMD_LOW_REV, 7'h00, 1'h1, 0);
        check("led", 16'h0001, {15'h0000, red_led});
        stall <= 1'h1;
        send(CMD_HALT_QUERY, 7'h00, 1'h0, 2);
        check("halting", 16'h0e80, rep);
        check("cleared", 16'h0000, halting_flags);
        send(CMD_OCC_QUERY, 7'h00, 1'h0, 2);
        check("occurred", 16'h0e80, rep & 16'hee80);
        send(CMD_OCC_QUERY, 7'h00, 1'h0, 2);
        check("occurred again", 16'h0000, rep & 16'hee80);
        {stall, err_enable[ERR_OVERRUN]} <= 2'h1;
        $display("event test done");
    endtask : t_events
    task automatic t_levels();
        {no_power, driver_fault, in_aux_open} <= 3'h7;
        {feedback, motor_current} <= {12'hff8, 8'hc9};
        {malformed_evt, overrun_evt} <= 2'h3;
        @(posedge clk);
        {malformed_evt, overrun_evt} <= 2'h0;
        repeat (3) @(posedge clk);
        check("levels", 16'h0976, halting_flags);
        {no_power, driver_fault, in_aux_open, fb_aux_open} <= 4'h1;
        {feedback, motor_current, analog_input} <= {12'h321, 8'h37, 12'hff8};
        serial_tmo_en <= 1'h1;
        send(CMD_HALT_QUERY, 7'h00, 1'h0, 2);
        repeat (60) @(posedge clk);
        check("limits", 16'h1030, halting_flags);
        {fb_aux_open, serial_tmo_en, analog_input} <= {2'h0, 12'h5a3};
        send(CMD_HALT_QUERY, 7'h00, 1'h0, 2);
        check("clear", 16'h0000, halting_flags);
        $display("level test done");
    endtask : t_levels
    task automatic t_pulse();
        input_mode <= IN_MODE_PULSE;
        pulses(4, 1'h1, 12'h2bc);
        send(CMD_READ_TWO, 7'h00, 1'h0, 2);
        check("pulse value", 16'h02bc, rep);
        pulses(3, 1'h1, 12'h2bc);
        pulses(1, 1'h0, 12'h1f4);
        pulses(3, 1'h1, 12'h1f4);
        send(CMD_READ_TWO, 7'h00, 1'h0, 2);
        check("pulse held", 16'h02bc, rep);
        pulses(1, 1'h1, 12'h1f4);
        send(CMD_READ_TWO, 7'h00, 1'h0, 2);
        check("pulse new", 16'h01f4, rep);
        repeat (60) @(posedge clk);
        check("invalid", 16'h0008, halting_flags & 16'h0008);
        input_mode <= IN_MODE_ANALOG;
        @(posedge clk);
        send(CMD_HALT_QUERY, 7'h00, 1'h0, 2);
        repeat (60) @(posedge clk);
        check("no invalid", 16'h0000, halting_flags);
        $display("pulse test done");
    endtask : t_pulse
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        check("reset", 16'h0001, halting_flags);
        t_reads();
        t_setpoint();
        t_events();
        t_levels();
        t_pulse();
        conclude();
    end
    // whole run needs a few hundred cycles
    initial begin
        #(8 * 30000);
        miscompares++;
        conclude();
    end
endmodule : mfq_fault_query_bench
bind mfq_fault_query mfq_fault_query_chk u_chk (.clk, .rst, .cmd_valid,
    .cmd_byte, .cmd_crc_bad, .motor_current, .current_limit, .err_enable,
    .period_tick, .tx_ready, .cmd_ready, .tx_valid, .tx_data, .motor_drive,
    .red_led, .err_line, .halting_flags, .control_period_counter);
`default_nettype wire
